// *** hcrp_host_model.sv ***
//****************************************************************
// hcrp_host_model - host processor on the i/o pins
//****************************************************************
// Purpose : one whole host access per call
// Assumes : pins change one nanosecond after a rising edge
// Notes   : released pins show inverted garbage, never old values
`timescale 1ns/1ns
module hcrp_host_model (
    // clock
    input wire logic                clk,
    // host pins and returned data
    output hcrp_pkg::hcrp_bus_t     io_bus,
    input wire logic         [31:0] io_rdata
);
    import hcrp_pkg::*;
    // pins idle at time zero
    initial io_bus = '0;
    // strobe and fields held five edges, data taken at the last
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [3:0] b, input logic [31:0] v,
                       output logic [31:0] r);
        @(posedge clk);
        #1;
        io_bus = '{sel: 1'b1, we: w, addr: a, be: b, wdata: v};
        repeat (5) @(posedge clk);
        r = io_rdata;
        #1;
        io_bus = '{sel: 1'b0, we: ~w, addr: ~a, be: ~b, wdata: ~v};
        repeat (3) @(posedge clk);
    endtask
endmodule

// *** hcrp_pkg.sv ***
//****************************************************************
// hcrp_pkg - shared constants and carriers
//****************************************************************
// Purpose : offsets, fields, reset values and timing of the port
// Assumes : 20 MHz core clock
// Notes   : all numbers of the register port live here, except the ready-test and i/o command codes
package hcrp_pkg;

    //************************************************************
    // timing
    //************************************************************
    localparam longint unsigned HCRP_CLK_HZ      = 64'd20_000_000;
    localparam longint unsigned HCRP_TIMEOUT_S   = 64'd120; // 2 min
    localparam longint unsigned HCRP_TIMEOUT_CYC =
        HCRP_TIMEOUT_S * HCRP_CLK_HZ;
    localparam int              HCRP_TMR_W       = 32;

    //************************************************************
    // address decode
    //************************************************************
    localparam int         HCRP_ADDR_W   = 16;
    localparam logic [2:0] HCRP_OFS_PARAM = 3'h0;
    localparam logic [2:0] HCRP_OFS_CMD   = 3'h4;
    localparam logic [2:0] HCRP_OFS_CTRL  = 3'h5;
    localparam logic [2:0] HCRP_OFS_ERR   = 3'h6;
    localparam logic [2:0] HCRP_OFS_STAT  = 3'h7;
    localparam int         HCRP_BASE_LSB  = 10;  // 1 KB boundary

    //************************************************************
    // control byte fields and values
    //************************************************************
    localparam int         HCRP_CTL_RST   = 7;  // command reset
    localparam int         HCRP_CTL_COR   = 6;  // clear on read
    localparam int         HCRP_CTL_RREJ  = 5;  // stored, no effect
    localparam int         HCRP_CTL_DMA   = 1;  // bus master enable
    localparam int         HCRP_CTL_IEN   = 0;  // host irq enable
    localparam logic [7:0] HCRP_CTL_WMASK = 8'he3;
    localparam logic [7:0] HCRP_CTL_POR   = 8'h00;
    localparam logic [7:0] HCRP_CTL_CRST  = 8'h80;

    //************************************************************
    // status byte fields and values
    //************************************************************
    localparam logic [7:0] HCRP_ST_POR   = 8'h01;
    localparam logic [2:0] HCRP_CODE_OK   = 3'h2;
    localparam logic [2:0] HCRP_CODE_PIPE = 3'h3;
    localparam logic [2:0] HCRP_CODE_DEV  = 3'h4;
    localparam logic [2:0] HCRP_CODE_CAT  = 3'h7;

    //************************************************************
    // error codes and command digits
    //************************************************************
    localparam logic [6:0] HCRP_ERR_FIRST    = 7'h01;
    localparam logic [6:0] HCRP_ERR_LAST     = 7'h25;
    localparam logic [6:0] HCRP_ERR_TIMEOUT  = 7'h22;
    localparam logic [6:0] HCRP_ERR_NO_READY = 7'h40; // missing test
    localparam logic [6:0] HCRP_ERR_BOOT_END = 7'h47;
    localparam logic [3:0] HCRP_BOOT_DIGIT   = 4'hd;

    //************************************************************
    // carriers
    //************************************************************
    typedef struct packed {
        logic        sel;    // access strobe, level
        logic        we;     // 1 write, 0 read
        logic [15:0] addr;   // byte address
        logic [3:0]  be;     // byte lane enables
        logic [31:0] wdata;  // write data
    } hcrp_bus_t;
    localparam int HCRP_BUS_W = $bits(hcrp_bus_t);

    typedef struct packed {
        logic       load;     // one-cycle load strobe
        logic [7:0] err;      // error byte, bit 7 source
        logic [2:0] code;     // interrupt cause
        logic       raise;    // raise the interrupt bit
        logic       selftest; // second self-test phase running
        logic       done;     // command processed, drop busy
    } hcrp_mc_in_t;

    typedef struct packed {
        logic        start;         // adapter interrupt pulse
        logic [7:0]  code;          // code written with start
        logic [31:0] param;         // parameter word
        logic        adapter_reset; // command reset level
        logic        bus_master_en; // bus master allowed
    } hcrp_mc_out_t;

    typedef struct packed {
        logic [31:0] param;
        logic [7:0]  cmd;
        logic [7:0]  ctrl;
        logic [7:0]  err;
        logic [2:0]  code;
        logic        selftest;
        logic        intr;
        logic        busy;
        logic        ready_seen;
        logic        sel_d;
        logic [31:0] rdata;
        logic        start;
        logic [7:0]  start_code;
        logic        irq;
    } hcrp_state_t;

endpackage

// *** hcrp_port.sv ***
//****************************************************************
// hcrp_port - host command register port
//****************************************************************
// Purpose : parameter, command, control, error and status bytes
// Assumes : host pins are asynchronous and held for 3+ cycles
// Notes   : microcode side runs on the same clock
`timescale 1ns/1ns
module hcrp_port
    import hcrp_pkg::*;
#(
    parameter longint unsigned TIMEOUT_CYCLES = HCRP_TIMEOUT_CYC,
    parameter logic [7:0]      READY_TEST_CMD = 8'h01,
    parameter logic [7:0]      EXEC_IO_CMD    = 8'h02
) (
    // clock and channel reset
    input  wire logic                        clk,
    input  wire logic                        resetn,
    // host i/o bus pins
    input  wire hcrp_pkg::hcrp_bus_t         io_bus,
    output logic                      [31:0] io_rdata,
    output logic                             host_irq,
    // configuration: base address bits 15..10
    input  wire logic                  [5:0] base_sel,
    // microcode side
    input  wire hcrp_pkg::hcrp_mc_in_t       mc_in,
    output hcrp_pkg::hcrp_mc_out_t           mc_out
);
    import hcrp_pkg::*;

    //************************************************************
    // declarations
    //************************************************************
    logic [HCRP_BUS_W-1:0] bus_raw;     // pins as a vector
    logic [HCRP_BUS_W-1:0] bus_vec;     // synchronised vector
    hcrp_bus_t             bus_q;       // synchronised bundle
    logic                  hit;         // address in our window
    logic                  take;        // access taken this cycle
    logic                  wr_lo;       // write to parameter word
    logic                  wr_hi;       // write to byte word
    logic                  rd_hi;       // read of byte word
    logic                  rd_lo;       // read of parameter word
    logic                  boot_digit;  // written code is Dh-
    logic                  timeout;     // watchdog pulse
    logic                  tmr_run;     // watchdog enable
    logic [7:0]            status_val;  // status as read
    hcrp_state_t           r_reg;       // registered state
    hcrp_state_t           r_next;      // next state

    //************************************************************
    // host pin synchroniser
    //************************************************************
    assign bus_raw = io_bus;

    hcrp_sync #(
        .W      (HCRP_BUS_W)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (bus_raw),
        .q      (bus_vec)
    );

    assign bus_q = bus_vec;

    //************************************************************
    // decode
    //************************************************************
    // base on any 1 KB boundary, eight bytes used
    assign hit  = (bus_q.addr[15:HCRP_BASE_LSB] == base_sel) &&
                  (bus_q.addr[HCRP_BASE_LSB-1:3] == '0);
    // one access per rising edge of the strobe
    assign take  = bus_q.sel && !r_reg.sel_d && hit;
    assign wr_lo = take && bus_q.we && !bus_q.addr[2];
    assign wr_hi = take && bus_q.we && bus_q.addr[2];
    assign rd_lo = take && !bus_q.we && !bus_q.addr[2];
    assign rd_hi = take && !bus_q.we && bus_q.addr[2];

    // upper digit of the written command code
    assign boot_digit = (bus_q.wdata[7:4] == HCRP_BOOT_DIGIT);

    // reserved status bits 4 and 2 read as zero
    assign status_val = {r_reg.code, 1'b0, r_reg.selftest,
                         1'b0, r_reg.intr, r_reg.busy};

    //************************************************************
    // transaction watchdog
    //************************************************************
    // runs while a command is outstanding, not during reset
    assign tmr_run = r_reg.busy && !r_reg.ctrl[HCRP_CTL_RST];

    hcrp_timer #(
        .W       (HCRP_TMR_W),
        .LIMIT   (TIMEOUT_CYCLES)
    ) u_timer (
        .clk     (clk),
        .resetn  (resetn),
        .run     (tmr_run),
        .clr     (r_reg.start),
        .expired (timeout)
    );

    //************************************************************
    // next state
    //************************************************************
    always_comb begin
        r_next       = r_reg;
        r_next.start = 1'b0;
        r_next.sel_d = bus_q.sel;

        // parameter word, byte lanes, gated by busy
        if (wr_lo && !r_reg.busy) begin
            for (int i = 0; i < 4; i++) begin
                if (bus_q.be[i]) begin
                    r_next.param[8*i +: 8] = bus_q.wdata[8*i +: 8];
                end
            end
        end // else dropped while busy

        // command byte on lane 0
        if (wr_hi && bus_q.be[0]) begin
            if (!r_reg.busy) begin
                if ((bus_q.wdata[7:0] == EXEC_IO_CMD) &&
                    !r_reg.ready_seen) begin
                    // boot i/o refused, no readiness test yet
                    r_next.cmd  = bus_q.wdata[7:0];
                    r_next.err  = {1'b0, HCRP_ERR_NO_READY};
                    r_next.code = HCRP_CODE_DEV;
                    r_next.intr = 1'b1;
                end else begin
                    // accepted: store, go busy, start adapter
                    r_next.cmd        = bus_q.wdata[7:0];
                    r_next.busy       = 1'b1;
                    r_next.start      = 1'b1;
                    r_next.start_code = bus_q.wdata[7:0];
                    if (bus_q.wdata[7:0] == READY_TEST_CMD) begin
                        r_next.ready_seen = 1'b1;
                    end
                end
            end else if (boot_digit) begin
                // busy: byte kept, only Dh- codes still interrupt
                r_next.start      = 1'b1;
                r_next.start_code = bus_q.wdata[7:0];
            end
        end

        // control byte on lane 1
        if (wr_hi && bus_q.be[1]) begin
            if (bus_q.wdata[8 + HCRP_CTL_RST]) begin
                // command reset: fixed value, status masked
                r_next.ctrl       = HCRP_CTL_CRST;
                r_next.intr       = 1'b0;
                r_next.busy       = 1'b1;
                r_next.ready_seen = 1'b0;
            end else begin
                // bit 5 is just stored
                r_next.ctrl = bus_q.wdata[15:8] & HCRP_CTL_WMASK;
                if (r_reg.ctrl[HCRP_CTL_RST]) begin
                    // reset released: adapter is idle again
                    r_next.busy = 1'b0;
                end
            end
        end

        // read data, captured and held until the next read
        if (rd_lo) begin
            r_next.rdata = r_reg.param;
        end else if (rd_hi) begin
            r_next.rdata = {status_val, r_reg.err, r_reg.ctrl, r_reg.cmd};
            // status read clears interrupt if enabled
            if (bus_q.be[3] && r_reg.ctrl[HCRP_CTL_COR]) begin
                r_next.intr = 1'b0;
            end
        end

        // microcode load, after the read so a set wins
        if (mc_in.load) begin
            r_next.err      = mc_in.err;
            r_next.code     = mc_in.code;
            r_next.selftest = mc_in.selftest;
            if (mc_in.raise) begin
                r_next.intr = 1'b1;
            end
            if (mc_in.done && !r_reg.start) begin
                r_next.busy = 1'b0;
            end
        end

        // transaction outstanding too long
        if (timeout) begin
            r_next.err  = {1'b0, HCRP_ERR_TIMEOUT};
            r_next.code = HCRP_CODE_CAT;
            r_next.intr = 1'b1;
            r_next.busy = 1'b0;
        end

        // reset in progress keeps busy
        if (r_next.ctrl[HCRP_CTL_RST]) begin
            r_next.busy = 1'b1;
        end

        // host interrupt only when enabled
        r_next.irq = r_next.ctrl[HCRP_CTL_IEN] && r_next.intr;
    end

    //************************************************************
    // registers
    //************************************************************
    // channel reset: control 00h, status 01h, rest cleared
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg            <= '0;
            r_reg.ctrl       <= HCRP_CTL_POR;
            r_reg.code       <= HCRP_ST_POR[7:5];
            r_reg.selftest   <= HCRP_ST_POR[3];
            r_reg.intr       <= HCRP_ST_POR[1];
            r_reg.busy       <= HCRP_ST_POR[0];
        end else begin
            r_reg <= r_next;
        end
    end

    //************************************************************
    // outputs, straight from flops
    //************************************************************
    assign io_rdata = r_reg.rdata;
    assign host_irq = r_reg.irq;

    // self-test never gates command start
    assign mc_out.start         = r_reg.start;
    assign mc_out.code          = r_reg.start_code;
    assign mc_out.param         = r_reg.param;
    assign mc_out.adapter_reset = r_reg.ctrl[HCRP_CTL_RST];
    assign mc_out.bus_master_en = r_reg.ctrl[HCRP_CTL_DMA];

endmodule

// *** hcrp_port_assertions.sv ***
//****************************************************************
// hcrp_port_assertions - port-level checks on the register port
//****************************************************************
// Purpose : tie outputs to the host accesses that cause them
// Assumes : host holds pins five cycles per access
// Notes   : bound into every hcrp_port instance
`timescale 1ns/1ns
module hcrp_port_assertions (
    // clock and channel reset
    input wire logic                   clk,
    input wire logic                   resetn,
    // watched ports
    input wire hcrp_pkg::hcrp_bus_t    io_bus,
    input wire logic            [31:0] io_rdata,
    input wire logic                   host_irq,
    input wire logic             [5:0] base_sel,
    input wire hcrp_pkg::hcrp_mc_in_t  mc_in,
    input wire hcrp_pkg::hcrp_mc_out_t mc_out
);
    import hcrp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a start is one cycle long and not repeated at once
    AST_START_SPACING: assert property (
        mc_out.start |=> !mc_out.start [*3])
        else $error("start pulse too long or repeated");
    // a start comes from a write to the command byte at the base
    AST_START_CAUSE: assert property (mc_out.start |->
        $past(io_bus.we, 2) && mc_out.code == $past(io_bus.wdata[7:0], 2)
        && $past(io_bus.addr, 2) == {base_sel, 7'h00, HCRP_OFS_CMD})
        else $error("start without matching command write");
    // parameter word moves only on a parameter write
    AST_PARAM_WRITE: assert property (!$stable(mc_out.param) |->
        $past(io_bus.sel, 2) && $past(io_bus.we, 2)
        && !$past(io_bus.addr[2], 2))
        else $error("parameter word changed without a write");
    // host interrupt drops only through a host access
    AST_IRQ_FALL: assert property ($fell(host_irq) |->
        $past(io_bus.sel, 2) && $past(io_bus.addr[2], 2))
        else $error("host interrupt dropped without access");
    // command reset enters only on a control write with bit 7
    AST_RST_RISE: assert property ($rose(mc_out.adapter_reset) |->
        $past(io_bus.we, 2) && $past(io_bus.be[1], 2)
        && $past(io_bus.wdata[15], 2))
        else $error("command reset without control write");
    // command reset leaves only on a control write with bit 7 clear
    AST_RST_FALL: assert property ($fell(mc_out.adapter_reset) |->
        $past(io_bus.we, 2) && !$past(io_bus.wdata[15], 2))
        else $error("command reset left without control write");
    // bus master enable follows the written control bit
    AST_BM_CHANGE: assert property ($changed(mc_out.bus_master_en) |->
        $past(io_bus.we, 2) && $past(io_bus.be[1], 2)
        && mc_out.bus_master_en == $past(io_bus.wdata[9], 2))
        else $error("bus master enable changed on its own");
    // read data moves only on a host read
    AST_RDATA_HOLD: assert property ($changed(io_rdata) |->
        $past(io_bus.sel, 2) && !$past(io_bus.we, 2))
        else $error("read data changed without a read");
endmodule
bind hcrp_port hcrp_port_assertions u_hcrp_port_assertions (
    .clk(clk), .resetn(resetn), .io_bus(io_bus), .io_rdata(io_rdata),
    .host_irq(host_irq), .base_sel(base_sel), .mc_in(mc_in),
    .mc_out(mc_out));

// *** hcrp_sync.sv ***
//****************************************************************
// hcrp_sync - two flop synchroniser for a bundle of pins
//****************************************************************
// Purpose : bring asynchronous host bus pins into the core clock
// Assumes : multi-bit fields are stable while the strobe is held
// Notes   : only the second stage is visible outside
`timescale 1ns/1ns
module hcrp_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // pins in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    //************************************************************
    // state
    //************************************************************
    typedef struct packed {
        logic [W-1:0] s1;  // first stage, metastable
        logic [W-1:0] s2;  // second stage, safe
    } hcrp_sync_t;

    hcrp_sync_t r_reg;     // registered state
    hcrp_sync_t r_next;    // next state

    // shift the pins through both stages
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    // register the state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.s2;

endmodule

// *** hcrp_timer.sv ***
//****************************************************************
// hcrp_timer - watchdog on an outstanding host transaction
//****************************************************************
// Purpose : pulse once when run stays high for LIMIT cycles
// Assumes : LIMIT fits in W bits
// Notes   : dropping run or a clear restarts the count
`timescale 1ns/1ns
module hcrp_timer #(
    parameter int                   W     = 32,
    parameter longint unsigned      LIMIT = 64'd2_400_000_000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // control
    input  wire logic run,
    input  wire logic clr,
    // one-cycle expiry pulse
    output logic      expired
);

    localparam logic [W-1:0] LAST = W'(LIMIT - 64'd1);

    //************************************************************
    // state
    //************************************************************
    typedef struct packed {
        logic [W-1:0] cnt;   // cycles spent running
        logic         fired; // expiry already reported
        logic         pulse; // registered expiry
    } hcrp_timer_t;

    hcrp_timer_t r_reg;      // registered state
    hcrp_timer_t r_next;     // next state

    // count while running, fire once at the limit
    always_comb begin
        r_next       = r_reg;
        r_next.pulse = 1'b0;
        if (clr || !run) begin
            r_next.cnt   = '0;
            r_next.fired = 1'b0;
        end else if (!r_reg.fired) begin
            if (r_reg.cnt == LAST) begin
                r_next.pulse = 1'b1;
                r_next.fired = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt + 1'b1;
            end
        end
    end

    // register the state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign expired = r_reg.pulse;

endmodule

// *** test_hcrp_port.sv ***
//****************************************************************
// test_hcrp_port - self-checking bench of the register port
//****************************************************************
// Purpose : host and microcode traffic against expected bytes
// Assumes : base at 1 KB slot 5, watchdog count shortened
// Notes   : word 4 reads {status, error, control, command}
`timescale 1ns/1ns
module test_hcrp_port;
    import hcrp_pkg::*;
    localparam int          TMO = 100;      // shortened timeout
    localparam logic [15:0] BA  = 16'h1400; // register base
    logic         clk = 1'b0;
    logic         resetn = 1'b0;
    hcrp_bus_t    io_bus;
    logic [31:0]  io_rdata;
    logic         host_irq;
    hcrp_mc_in_t  mc_in = '0;
    hcrp_mc_out_t mc_out;
    int           err_total = 0;
    int           checked = 0;
    int           starts = 0;   // adapter interrupts seen
    logic [7:0]   scode = 8'h00; // code of the last start
    logic [31:0]  d;             // last read word
    always #25 clk = ~clk;
    hcrp_port #(.TIMEOUT_CYCLES(TMO)) u_hcrp_port (.clk(clk),
        .resetn(resetn), .io_bus(io_bus), .io_rdata(io_rdata),
        .host_irq(host_irq), .base_sel(BA[15:10]), .mc_in(mc_in),
        .mc_out(mc_out));
    hcrp_host_model u_hcrp_host_model (.clk(clk), .io_bus(io_bus),
        .io_rdata(io_rdata));
    // count start pulses
    always @(posedge clk) begin
        if (mc_out.start === 1'b1) begin
            starts++;
            scode = mc_out.code;
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] b,
                      input logic [31:0] v);
        logic [31:0] x;
        u_hcrp_host_model.acc(1'b1, BA + a, b, v, x);
    endtask
    task automatic rd(input logic [15:0] a);
        u_hcrp_host_model.acc(1'b0, BA + a, 4'hf, 32'h0, d);
    endtask
    // one microcode load pulse
    task automatic mcl(input logic [7:0] e, input logic [2:0] c,
                       input logic r, input logic s, input logic n);
        @(posedge clk);
        #1;
        mc_in = '{load: 1'b1, err: e, code: c, raise: r, selftest: s,
                  done: n};
        @(posedge clk);
        #1;
        mc_in.load = 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic s_reset();
        wr(0, 4'hf, 32'h12345678);
        chk("busy param", 32'h0, mc_out.param);
        rd(4);
        chk("reset word", 32'h01000000, d);
        mcl(8'h00, 3'h0, 1'b0, 1'b0, 1'b1);
        wr(0, 4'hf, 32'hcafe0004);
        chk("param out", 32'hcafe0004, mc_out.param);
        rd(0);
        chk("param rd", 32'hcafe0004, d);
        wr(16'h0404, 4'h1, 32'h01);
        wr(16'h000c, 4'h1, 32'h01);
        wr(4, 4'hc, 32'hffff0000);
        rd(4);
        chk("ro bytes", 32'h0, d);
        chk("miss starts", 0, starts);
    endtask
    task automatic s_cmd();
        wr(4, 4'h1, 32'h10);
        chk("starts", 1, starts);
        chk("code", 8'h10, scode);
        rd(4);
        chk("busy", 32'h01000010, d);
        wr(4, 4'h1, 32'h20);
        chk("blocked", 1, starts);
        wr(4, 4'h1, 32'hd5);
        chk("d digit", 2, starts);
        rd(4);
        chk("cmd kept", 32'h01000010, d);
        mcl(8'h00, HCRP_CODE_OK, 1'b1, 1'b0, 1'b1);
        rd(4);
        rd(4);
        chk("no clear", 32'h42000010, d);
        chk("irq masked", 0, host_irq);
        wr(4, 4'h2, 32'h4100);
        chk("irq on", 1, host_irq);
        rd(4);
        chk("intr read", 32'h42004110, d);
        chk("irq clr", 0, host_irq);
        rd(4);
        chk("cleared", 32'h40004110, d);
    endtask
    task automatic s_ctrl();
        wr(4, 4'h2, 32'h6300);
        rd(4);
        chk("ctrl", 32'h40006310, d);
        chk("dma on", 1, mc_out.bus_master_en);
        wr(4, 4'h2, 32'h5c00);
        rd(4);
        chk("ctrl rsv", 32'h40004010, d);
        chk("dma off", 0, mc_out.bus_master_en);
        mcl(8'h00, HCRP_CODE_OK, 1'b1, 1'b0, 1'b0);
        wr(4, 4'h2, 32'h8000);
        chk("in reset", 1, mc_out.adapter_reset);
        rd(4);
        chk("reset word", 32'h41008010, d);
        repeat (1000) @(posedge clk);
        rd(4);
        chk("busy held", 32'h41008010, d);
        wr(4, 4'h2, 32'h4000);
        chk("out reset", 0, mc_out.adapter_reset);
        rd(4);
        chk("released", 32'h40004010, d);
        chk("param kept", 32'hcafe0004, mc_out.param);
    endtask
    task automatic s_ready();
        wr(4, 4'h1, 32'h02);
        chk("refused", 2, starts);
        rd(4);
        chk("no ready", 32'h82404002, d);
        wr(4, 4'h1, 32'h01);
        mcl(8'h00, 3'h0, 1'b0, 1'b0, 1'b1);
        wr(4, 4'h1, 32'h02);
        chk("exec io", 4, starts);
        chk("exec code", 8'h02, scode);
        mcl(8'h00, 3'h0, 1'b0, 1'b0, 1'b1);
    endtask
    task automatic s_mc();
        logic [2:0] cl [4] = '{HCRP_CODE_OK, HCRP_CODE_PIPE,
                                HCRP_CODE_DEV, HCRP_CODE_CAT};
        for (int i = 0; i < 4; i++) begin
            mcl(8'h85, cl[i], 1'b1, 1'b1, 1'b0);
            rd(4);
            chk("cause", {cl[i], 5'h0a}, d[31:24]);
            chk("err", 8'h85, d[23:16]);
        end
        wr(4, 4'h1, 32'h01);
        chk("selftest cmd", 5, starts);
        mcl(8'h00, 3'h0, 1'b0, 1'b0, 1'b1);
        rd(4);
        chk("selftest end", 0, d[27]);
    endtask
    task automatic s_timeout();
        wr(4, 4'h1, 32'h05);
        repeat (TMO + 10) @(posedge clk);
        rd(4);
        chk("timeout", 32'he2224005, d);
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (6000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1;
        resetn = 1'b1;
        s_reset();
        s_cmd();
        s_ctrl();
        s_ready();
        s_mc();
        s_timeout();
        give_verdict();
    end
endmodule
